/* logic/sram_port_pkg.sv */
// Purpose: Shared widths, reset values and operation codes for the
//          pipelined burst SRAM port.
// Assumes: Wide variant, four byte lanes with one parity bit each.
// Notes:   Memory depth matches the 18-bit word address.
package sram_port_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int ADDR_W = 18;
    localparam int LANES  = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH  = 262144;
    localparam int LOW_W  = 2;

    // ****************************************
    // Burst counter steps
    // ****************************************
    localparam logic [LOW_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [LOW_W-1:0] BEAT_STEP  = 2'h1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_RESET  = 18'h00000;
    localparam logic [DATA_W-1:0] DATA_RESET  = 32'h00000000;
    localparam logic [LANES-1:0]  LANES_OFF   = 4'hf;
    localparam logic [LANES-1:0]  PAR_RESET   = 4'h0;
    localparam logic              ORDER_RESET = 1'b1;

    // ****************************************
    // Operation held in the address stage
    // ****************************************
    typedef enum logic [2:0] {
        OP_IDLE  = 3'b001,
        OP_READ  = 3'b010,
        OP_WRITE = 3'b100
    } op_e;

endpackage

/* logic/burst_step.sv */
// Purpose: Low two address bits of one burst beat.
// Assumes: Beat index counts from zero at the loaded address.
// Notes:   Pure combinational; order comes from the latched strap.
`timescale 1ns/100ps
module burst_step (
    // Burst position
    input  wire logic [1:0] start,
    input  wire logic [1:0] beat,
    // Order select, high for interleaved
    input  wire logic       interleaved,
    // Resulting low address bits
    output logic      [1:0] low_bits
);

    // ****************************************
    // Sequence select
    // ****************************************
    // Both sequences stay inside the four-word group
    always_comb begin
        if (interleaved) begin
            low_bits = start ^ beat;
        end else begin
            low_bits = start + beat;
        end
    end

endmodule

/* logic/burst_sram_port.sv */
// Purpose: Pipelined burst SRAM core with byte-lane writes.
// Assumes: Inputs synchronous to clk; sleep_request may be asynchronous.
// Notes:   Reads return one edge after the address, writes take data
//          two edges after the address.
//
// Overview of operation
// - Inputs and read data pass through registers
// - Qualify high freezes all pipeline state unless sleep clears it
// - Load needs qualify, all selects, load low
// - Write select high starts a read
// - Read data driven after next clock rise
// - Read drivers only while drive enable low
// - New operation accepted every cycle
// - Deselect tristates after the next rise
// - Burst counter gives four accesses per address
// - Order strap: low linear, high interleaved
// - Counter touches two low bits, wraps
// - Advance ignores selects and write select
// - Access type fixed for whole burst
// - Write start loads address and lane selects
// - Write data phase forces data tristated
// - Write data captured second rise after address
// - Only selected byte lanes are written
// - Sleep request high enters data-safe sleep
// - Interleaved beat is start xor index
// - Linear beat is start plus index
// - Parity bit follows its byte lane
// - All lanes off means write abort
`timescale 1ns/100ps
module burst_sram_port (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              reset,
    // Address and controls
    input  wire logic [sram_port_pkg::ADDR_W-1:0]  address,
    input  wire logic                              select_a_n,
    input  wire logic                              select_b,
    input  wire logic                              select_c_n,
    input  wire logic                              advance_or_load,
    input  wire logic                              write_select_n,
    input  wire logic [sram_port_pkg::LANES-1:0]   byte_lane_write_n,
    input  wire logic                              clock_qualify_n,
    input  wire logic                              output_drive_enable_n,
    // Static configuration and power
    input  wire logic                              burst_order,
    input  wire logic                              sleep_request,
    // Data lines
    input  wire logic [sram_port_pkg::DATA_W-1:0]  data_lines_in,
    output logic      [sram_port_pkg::DATA_W-1:0]  data_lines_out,
    output logic                                   data_lines_oe,
    // Parity lines
    input  wire logic [sram_port_pkg::LANES-1:0]   parity_lines_in,
    output logic      [sram_port_pkg::LANES-1:0]   parity_lines_out,
    output logic                                   parity_lines_oe,
    // Status
    output logic                                   sleep_state
);
    import sram_port_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic                sleep_meta;
    logic                sleep_sync;
    logic                order_interleaved;
    logic                go;
    logic                selected;
    op_e                 s1_op;
    op_e                 next_op;
    logic [ADDR_W-1:0]   s1_addr;
    logic [ADDR_W-1:0]   next_addr;
    logic [LOW_W-1:0]    s1_start;
    logic [LOW_W-1:0]    next_start;
    logic [LOW_W-1:0]    s1_beat;
    logic [LOW_W-1:0]    next_beat;
    logic [LOW_W-1:0]    adv_beat;
    logic [LOW_W-1:0]    burst_low;
    logic [LANES-1:0]    s1_bw;
    logic                s2_write;
    logic [ADDR_W-1:0]   s2_addr;
    logic [LANES-1:0]    s2_bw;
    logic                out_active;
    logic [DATA_W-1:0]   out_data;
    logic [LANES-1:0]    out_par;
    logic [DATA_W-1:0]   rd_data;
    logic [LANES-1:0]    rd_par;
    logic [DATA_W-1:0]   mem_data [0:DEPTH-1];
    logic [LANES-1:0]    mem_par  [0:DEPTH-1];

    // ****************************************
    // Sleep request synchroniser
    // ****************************************
    // two-stage sync
    // Pin may change at any time, so two flops before use
    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_meta <= 1'b0;
            sleep_sync <= 1'b0;
        end else begin
            sleep_meta <= sleep_request;
            sleep_sync <= sleep_meta;
        end
    end

    assign sleep_state = sleep_sync;

    // ****************************************
    // Burst order strap
    // ****************************************
    // strap capture
    // Caught while reset is held; later changes are ignored
    always_ff @(posedge clk) begin
        if (reset) begin
            order_interleaved <= burst_order;
        end
    end

    // ****************************************
    // Edge qualification
    // ****************************************
    // edge qualify
    assign go       = !clock_qualify_n && !sleep_sync;
    assign selected = !select_a_n && select_b && !select_c_n;

    // ****************************************
    // Burst address generation
    // ****************************************
    // Index of the beat that the next advance produces
    assign adv_beat = s1_beat + BEAT_STEP;

    burst_step u_burst_step (
        .start       (s1_start),
        .beat        (adv_beat),
        .interleaved (order_interleaved),
        .low_bits    (burst_low)
    );

    // ****************************************
    // Next operation decode
    // ****************************************
    always_comb begin
        next_op    = s1_op;
        next_addr  = s1_addr;
        next_start = s1_start;
        next_beat  = s1_beat;
        if (advance_or_load) begin
            case (s1_op)
                OP_READ, OP_WRITE: begin
                    next_beat = adv_beat;
                    next_addr = {s1_addr[ADDR_W-1:LOW_W], burst_low};
                end
                OP_IDLE: begin
                    next_op = OP_IDLE;
                end
                default: begin
                    next_op = OP_IDLE;
                end
            endcase
        end else if (!selected) begin
            next_op = OP_IDLE;
        end else begin
            next_op    = write_select_n ? OP_READ : OP_WRITE;
            next_addr  = address;
            next_start = address[LOW_W-1:0];
            next_beat  = BEAT_FIRST;
        end
    end

    // ****************************************
    // Address stage
    // ****************************************
    // input register
    always_ff @(posedge clk) begin
        if (reset || sleep_sync) begin
            s1_op    <= OP_IDLE;
            s1_addr  <= ADDR_RESET;
            s1_start <= BEAT_FIRST;
            s1_beat  <= BEAT_FIRST;
            s1_bw    <= LANES_OFF;
        end else if (go) begin
            s1_op    <= next_op;
            s1_addr  <= next_addr;
            s1_start <= next_start;
            s1_beat  <= next_beat;
            // Lane selects are sampled on every beat of a write
            s1_bw    <= byte_lane_write_n;
        end
    end

    // ****************************************
    // Write data stage
    // ****************************************
    // data phase slot
    always_ff @(posedge clk) begin
        if (reset || sleep_sync) begin
            s2_write <= 1'b0;
            s2_addr  <= ADDR_RESET;
            s2_bw    <= LANES_OFF;
        end else if (go) begin
            s2_write <= (s1_op == OP_WRITE);
            s2_addr  <= s1_addr;
            s2_bw    <= s1_bw;
        end
    end

    // ****************************************
    // Memory array write
    // ****************************************
    // capture write data
    // abort when no lane
    // No reset here: contents must survive reset and sleep
    always_ff @(posedge clk) begin
        if (!reset && go && s2_write) begin
            for (int i = 0; i < LANES; i++) begin
                if (!s2_bw[i]) begin
                    mem_data[s2_addr][i*LANE_W +: LANE_W] <=
                        data_lines_in[i*LANE_W +: LANE_W];
                    mem_par[s2_addr][i] <= parity_lines_in[i];
                end
            end
        end
    end

    // ****************************************
    // Read word with write bypass
    // ****************************************
    // A write committing on the same edge as the read fetch would
    // otherwise return stale bytes on back-to-back write then read
    always_comb begin
        rd_data = mem_data[s1_addr];
        rd_par  = mem_par[s1_addr];
        if (s2_write && (s2_addr == s1_addr)) begin
            for (int i = 0; i < LANES; i++) begin
                if (!s2_bw[i]) begin
                    rd_data[i*LANE_W +: LANE_W] =
                        data_lines_in[i*LANE_W +: LANE_W];
                    rd_par[i] = parity_lines_in[i];
                end
            end
        end
    end

    // ****************************************
    // Output register
    // ****************************************
    // output register
    always_ff @(posedge clk) begin
        if (reset || sleep_sync) begin
            out_active <= 1'b0;
            out_data   <= DATA_RESET;
            out_par    <= PAR_RESET;
        end else if (go) begin
            out_active <= (s1_op == OP_READ);
            if (s1_op == OP_READ) begin
                out_data <= rd_data;
                out_par  <= rd_par;
            end
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    // drive enable gate
    // partner waits for release
    // Drive enable acts at once, so the partner can force release
    assign data_lines_out   = out_data;
    assign parity_lines_out = out_par;
    assign data_lines_oe    = out_active && !output_drive_enable_n
                              && !sleep_sync;
    assign parity_lines_oe  = data_lines_oe;

    // ****************************************
    // Assertions
    // ****************************************
    property p_read_latency;
        @(posedge clk) disable iff (reset)
        (go && s1_op == OP_READ) |=> out_active;
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("read result not ready one edge later");

    property p_stall_hold;
        @(posedge clk) disable iff (reset)
        (clock_qualify_n && !sleep_sync)
            |=> $stable(s1_op) && $stable(s1_addr) && $stable(out_active);
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("state changed on a stalled edge");

    property p_write_tristate;
        @(posedge clk) disable iff (reset)
        (go && s1_op == OP_WRITE)
            |=> !data_lines_oe && !parity_lines_oe;
    endproperty
    a_write_tristate: assert property (p_write_tristate)
        else $error("data driven during write data phase");

    property p_deselect;
        @(posedge clk) disable iff (reset)
        (go && !advance_or_load && !selected) ##1 go
            |=> !data_lines_oe && !parity_lines_oe && !out_active;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("outputs active after deselect");

    property p_oe_gate;
        @(posedge clk) disable iff (reset)
        output_drive_enable_n |-> !data_lines_oe && !parity_lines_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("driving while drive enable is high");

    property p_burst_type;
        @(posedge clk) disable iff (reset)
        (go && advance_or_load && s1_op != OP_IDLE)
            |=> s1_op == $past(s1_op);
    endproperty
    a_burst_type: assert property (p_burst_type)
        else $error("access type changed inside burst");

    property p_linear_step;
        @(posedge clk) disable iff (reset)
        (go && advance_or_load && s1_op != OP_IDLE && !order_interleaved)
            |=> s1_addr[1:0] == $past(s1_addr[1:0]) + 2'h1
                && s1_addr[ADDR_W-1:2] == $past(s1_addr[ADDR_W-1:2]);
    endproperty
    a_linear_step: assert property (p_linear_step)
        else $error("linear burst step wrong");

    property p_interleave;
        @(posedge clk) disable iff (reset)
        (s1_op != OP_IDLE && order_interleaved)
            |-> s1_addr[1:0] == (s1_start ^ s1_beat);
    endproperty
    a_interleave: assert property (p_interleave)
        else $error("interleaved burst address wrong");

    property p_sleep_quiet;
        @(posedge clk) disable iff (reset)
        sleep_sync |=> !data_lines_oe && s1_op == OP_IDLE && !s2_write;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("activity while asleep");

    property p_lane_write;
        @(posedge clk) disable iff (reset)
        (go && s2_write && !s2_bw[0])
            |=> mem_data[$past(s2_addr)][7:0] == $past(data_lines_in[7:0]);
    endproperty
    a_lane_write: assert property (p_lane_write)
        else $error("selected lane not written");

endmodule

/* dv/sram_bus_master.sv */
// Purpose: Bus master side of the shared data and parity wires.
// Assumes: The bench says when the write data phase is open.
// Notes:   A released wire shows the inverse of its last level.
`timescale 1ns/100ps
module sram_bus_master #(
    parameter int W = 36
) (
    // Clock
    input  wire logic         clk,
    // Write data from the bench
    input  wire logic         drive,
    input  wire logic [W-1:0] wr_word,
    // Device side of the wires
    input  wire logic [W-1:0] dev_word,
    input  wire logic         dev_oe,
    output logic      [W-1:0] bus_word
);
    logic [W-1:0] last_word = '0;

    always_comb begin
        if (dev_oe) begin
            bus_word = dev_word;
        end else if (drive) begin
            bus_word = wr_word;
        end else begin
            bus_word = ~last_word;
        end
    end

    // Keep last level so a released wire never looks held
    always_ff @(posedge clk) begin
        last_word <= bus_word;
    end
endmodule

/* dv/burst_sram_port_test.sv */
// Purpose: Self-checking bench for the pipelined burst SRAM port.
// Assumes: Traffic stays inside 64 words that are filled first.
// Notes:   Model steps on accepted edges only, so stalls hold it.
`timescale 1ns/100ps
module burst_sram_port_test;
    import sram_port_pkg::*;
    localparam int W = DATA_W + LANES;
    localparam logic [1:0] RD = 2'h1;
    localparam logic [1:0] WR = 2'h2;

    // ****************
    // Wires and model
    // ****************
    logic              clk = 1'b0, reset = 1'b1, burst_order = 1'b0;
    logic [ADDR_W-1:0] address = 18'h0;
    logic              select_a_n = 1'b1, select_b = 1'b0;
    logic              select_c_n = 1'b1, advance_or_load = 1'b0;
    logic              write_select_n = 1'b1, clock_qualify_n = 1'b0;
    logic [LANES-1:0]  byte_lane_write_n = 4'hf;
    logic              output_drive_enable_n = 1'b0;
    logic              sleep_request = 1'b0, wr_drive = 1'b0;
    logic [W-1:0]      bus_word, wr_word = 36'h0;
    logic [DATA_W-1:0] data_lines_out;
    logic [LANES-1:0]  parity_lines_out;
    logic              data_lines_oe, parity_lines_oe, sleep_state;
    logic [W-1:0]      mem [64];
    logic [W-1:0]      w1, w2, exp_word;
    logic [1:0]        k1, k2, btype, beat;
    logic [ADDR_W-1:0] a1, a2, base;
    logic [LANES-1:0]  b1, b2;
    logic              exp_act, asleep = 1'b0;
    int                fail_count = 0, tests_run = 0;

    always #4 clk = ~clk;

    burst_sram_port dut_u (
        .clk(clk),
        .reset(reset),
        .address(address),
        .select_a_n(select_a_n),
        .select_b(select_b),
        .select_c_n(select_c_n),
        .advance_or_load(advance_or_load),
        .write_select_n(write_select_n),
        .byte_lane_write_n(byte_lane_write_n),
        .clock_qualify_n(clock_qualify_n),
        .output_drive_enable_n(output_drive_enable_n),
        .burst_order(burst_order),
        .sleep_request(sleep_request),
        .data_lines_in(bus_word[DATA_W-1:0]),
        .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe),
        .parity_lines_in(bus_word[W-1:DATA_W]),
        .parity_lines_out(parity_lines_out),
        .parity_lines_oe(parity_lines_oe),
        .sleep_state(sleep_state)
    );

    sram_bus_master #(.W(W)) bus_u (
        .clk(clk),
        .drive(wr_drive),
        .wr_word(wr_word),
        .dev_word({parity_lines_out, data_lines_out}),
        .dev_oe(data_lines_oe),
        .bus_word(bus_word)
    );

    function automatic logic [1:0] low_bits(input logic [1:0] s, n,
                                            input logic ilv);
        return ilv ? (s ^ n) : (s + n);
    endfunction

    task automatic cmp(input logic [W-1:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One accepted edge: commit, read result, then load or advance
    task automatic model();
        if (k2 == WR) begin
            for (int i = 0; i < LANES; i++) begin
                if (!b2[i]) begin
                    mem[a2[5:0]][i*LANE_W +: LANE_W] =
                        w2[i*LANE_W +: LANE_W];
                    mem[a2[5:0]][DATA_W+i] = w2[DATA_W+i];
                end
            end
        end
        exp_act = (k1 == RD);
        exp_word = mem[a1[5:0]];
        if (asleep) begin
            btype = 2'h0;
        end else if (!advance_or_load) begin
            btype = (!select_a_n && select_b && !select_c_n) ?
                    (write_select_n ? RD : WR) : 2'h0;
            base = address;
            beat = 2'h0;
        end else begin
            beat = beat + 2'h1;
        end
        k2 = k1;
        a2 = a1;
        b2 = b1;
        w2 = w1;
        k1 = btype;
        a1 = {base[ADDR_W-1:2], low_bits(base[1:0], beat, burst_order)};
        b1 = byte_lane_write_n;
        w1 = W'({$urandom, $urandom});
    endtask

    // Check mid-cycle, since output enable is combinational
    task automatic step();
        logic en;
        @(negedge clk);
        en = exp_act & ~output_drive_enable_n;
        cmp(W'(data_lines_oe), W'(en));
        cmp(W'(parity_lines_oe), W'(en));
        if (exp_act) begin
            cmp({parity_lines_out, data_lines_out}, exp_word);
        end
        @(posedge clk);
        if (!clock_qualify_n && !reset) begin
            model();
        end
        #1;
        // data stands between the tristate and capture edges
        wr_drive = (k2 == WR);
        wr_word = w2;
    endtask

    task automatic put(input logic adv, we_n,
                       input logic [ADDR_W-1:0] a,
                       input logic [LANES-1:0] bw);
        {select_a_n, select_b, select_c_n} = 3'b010;
        clock_qualify_n = 1'b0;
        advance_or_load = adv;
        write_select_n = we_n;
        address = a;
        byte_lane_write_n = bw;
        step();
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            select_a_n = 1'b1;
            advance_or_load = 1'b0;
            clock_qualify_n = 1'b0;
            step();
        end
    endtask

    task automatic rnd();
        logic [31:0] r;
        r = $urandom;
        clock_qualify_n = (r[2:0] == 3'h0);
        advance_or_load = r[3];
        select_a_n = (r[6:4] == 3'h0);
        select_b = (r[9:7] != 3'h0);
        select_c_n = (r[12:10] == 3'h0);
        write_select_n = r[13];
        byte_lane_write_n = r[14] ? 4'h0 : r[18:15];
        output_drive_enable_n = (r[21:19] == 3'h0);
        if (r[22]) begin
            address = {12'h0, r[28:23]};
        end
        step();
    endtask

    task automatic do_reset(input logic order);
        reset = 1'b1;
        burst_order = order;
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        {k1, k2, btype, beat, exp_act} = 9'h0;
        wr_drive = 1'b0;
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        void'($urandom(56302));
        for (int o = 0; o < 2; o++) begin
            do_reset(o[0]);
            for (int i = 0; i < 64; i++) begin
                put(1'b0, 1'b0, ADDR_W'(i), 4'h0);
            end
            put(1'b0, 1'b0, 18'h5, 4'h5);
            put(1'b0, 1'b1, 18'h5, 4'hf);
            put(1'b1, 1'b0, 18'h5, 4'h0);
            put(1'b0, 1'b0, 18'h6, 4'hf);
            put(1'b0, 1'b1, 18'h6, 4'h0);
            idle(2);
            repeat (1500) rnd();
            idle(3);
        end
        // Sleep with loads offered that must be ignored
        sleep_request = 1'b1;
        output_drive_enable_n = 1'b0;
        idle(3);
        asleep = 1'b1;
        repeat (4) put(1'b0, 1'b1, 18'h5, 4'h0);
        cmp(W'(sleep_state), W'(1'b1));
        sleep_request = 1'b0;
        asleep = 1'b0;
        idle(4);
        cmp(W'(sleep_state), W'(1'b0));
        put(1'b0, 1'b1, 18'h5, 4'h0);
        idle(2);
        complete_run();
    end
endmodule
